/* File: tpg_pkg.sv */
// Package of constants and types for the ten-bit PWM generator
package tpg_pkg;
	localparam int          TPG_NUM_TMR     = 3;
	localparam logic [7:0]  TPG_OFS_CTRL    = 8'h00;
	localparam logic [7:0]  TPG_OFS_DUTY_HI = 8'h04;
	localparam logic [7:0]  TPG_OFS_DUTY_LO = 8'h08;
	localparam logic [7:0]  TPG_OFS_TSEL    = 8'h0C;
	localparam logic [7:0]  TPG_OFS_PINDIR  = 8'h10;
	localparam logic [7:0]  TPG_OFS_TCFG0   = 8'h20;
	localparam logic [7:0]  TPG_OFS_TPR0    = 8'h24;
	localparam logic [7:0]  TPG_TMR_STRIDE  = 8'h08;
	localparam int          TPG_CTRL_EN     = 7;
	localparam int          TPG_CTRL_OUT    = 5;
	localparam int          TPG_CTRL_POL    = 4;
	localparam int          TPG_DLO_POS     = 6;
	localparam int          TPG_TCFG_ON     = 7;
	localparam logic [1:0]  TPG_TSEL_RST    = 2'h1;
	localparam logic [1:0]  TPG_TSEL_RSVD   = 2'h0;
	localparam logic [9:0]  TPG_DUTY_RST    = 10'h000;
	localparam logic [7:0]  TPG_TPR_RST     = 8'hFF;
	localparam logic        TPG_PINDIR_RST  = 1'b1;
	localparam logic [1:0]  TPG_SUB_LAST    = 2'h3;
	localparam logic [1:0]  TPG_SUB_WIDTH_Q = 2'h2;

	typedef struct packed {
		logic [7:0] count;
		logic [1:0] sub;
		logic       step;
		logic       wrap;
	} tpg_tbase_t;

	typedef struct packed {
		logic       on;
		logic [2:0] presc;
		logic [7:0] limit;
	} tpg_tcfg_t;
endpackage

/* File: tpg_timer.sv */
// Eight-bit period timer with prescaler and two extra low bits
`timescale 1ns/1ps
module tpg_timer (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 sleep,
	input  wire tpg_pkg::tpg_tcfg_t   cfg,
	output tpg_pkg::tpg_tbase_t       tb
);
	logic [6:0] presc_cnt_r;
	logic [1:0] sub_r;
	logic [7:0] count_r;
	wire  [6:0] presc_lim = 7'((8'h01 << cfg.presc) - 8'h01);
	wire        adv       = cfg.on & ~sleep;
	wire        step      = adv & (presc_cnt_r == presc_lim);
	wire        carry     = step & (sub_r == tpg_pkg::TPG_SUB_LAST);
	wire        wrap      = carry & (count_r == cfg.limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_cnt_r <= 7'h00;
			sub_r       <= 2'h0;
			count_r     <= 8'h00;
		end else if (adv) begin
			presc_cnt_r <= step ? 7'h00 : presc_cnt_r + 7'h01;
			if (step)
				sub_r <= sub_r + 2'h1;
			if (wrap)
				count_r <= 8'h00;
			else if (carry)
				count_r <= count_r + 8'h01;
		end
	end

	// One driver for the whole struct keeps strict tools content
	assign tb = '{count: count_r, sub: sub_r, step: step, wrap: wrap};
endmodule

/* File: tpg_gen.sv */
// Duty compare stage with double-buffered duty value
`timescale 1ns/1ps
module tpg_gen (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 enable,
	input  wire logic                 sleep,
	input  wire logic [9:0]           duty_wr,
	input  wire tpg_pkg::tpg_tbase_t  tb,
	input  wire logic [7:0]           limit,
	output logic                      raw,
	output logic [9:0]                duty_act
);
	logic       raw_r;
	logic [9:0] duty_r;
	wire  [9:0]  ext_nxt = {tb.count, tb.sub} + 10'h001;
	wire  [10:0] full    = {1'b0, limit, 2'h3} + 11'h001;
	wire         reach   = ({1'b0, duty_r} < full) & (ext_nxt == duty_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_r  <= 1'b0;
			duty_r <= tpg_pkg::TPG_DUTY_RST;
		end else if (!enable) begin
			raw_r <= 1'b0;
		end else if (!sleep) begin
			if (tb.wrap) begin
				duty_r <= duty_wr;
				raw_r  <= (duty_wr != 10'h000);
			end else if (tb.step && reach) begin
				raw_r <= 1'b0;
			end
		end
	end

	assign raw      = raw_r;
	assign duty_act = duty_r;
endmodule

/* File: tpg_top.sv */
// APB-reached ten-bit PWM generator with three selectable timers
`timescale 1ns/1ps
// What this block does
// - Ten-bit duty resolution pulse output
// - Timer chosen per generator; first by default
// - Period from timer and limit only
// - Output goes active when timer clears, unless duty is zero
// - Output inactive when extended count equals duty
// - Duty at or above period: always active
// - Duty double buffered, loaded at period match
// - Match: clear count, load duty, set output if duty nonzero
// - Polarity bit inverts the output
// - Period is limit plus one, times four, times prescale
// - Two low bits extend count to ten
// - Resolution reaches ten bits at limit 255
// - Duty registers writable at any time
// - Shared period per timer, own duty
// - Sleep freezes count, state and output
// - Reset restores registers, pin becomes input
// - Generator runs only while enabled
// - Readable bit shows current output level
// - Select 01, 10, 11 picks timers; 00 reserved
module tpg_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        sleep_req,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             pwm_out,
	output logic             pin_out,
	output logic             pin_oe
);
	localparam int N = tpg_pkg::TPG_NUM_TMR;

	logic        en_r;
	logic        pol_r;
	logic [7:0]  duty_hi_r;
	logic [1:0]  duty_lo_r;
	logic [1:0]  tsel_r;
	logic        pindir_r;
	logic        sleep_s1_r;
	logic        sleep_s2_r;
	logic        pwm_r;
	logic        pin_oe_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        raw;
	logic [9:0]  duty_act;

	tpg_pkg::tpg_tcfg_t  tcfg_r [N];
	tpg_pkg::tpg_tbase_t tb     [N];
	tpg_pkg::tpg_tbase_t tb_sel;
	tpg_pkg::tpg_tcfg_t  cfg_sel;

	// Sleep arrives from another domain, so two flops first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_s1_r <= 1'b0;
			sleep_s2_r <= 1'b0;
		end else begin
			sleep_s1_r <= sleep_req;
			sleep_s2_r <= sleep_s1_r;
		end
	end

	wire setup_ph = psel & ~penable;
	wire wr_en    = psel & penable & pready_r & pwrite;
	wire hit_ctrl = (paddr == tpg_pkg::TPG_OFS_CTRL);
	wire hit_dhi  = (paddr == tpg_pkg::TPG_OFS_DUTY_HI);
	wire hit_dlo  = (paddr == tpg_pkg::TPG_OFS_DUTY_LO);
	wire hit_tsel = (paddr == tpg_pkg::TPG_OFS_TSEL);
	wire hit_pdir = (paddr == tpg_pkg::TPG_OFS_PINDIR);

	logic [N-1:0] hit_tcfg;
	logic [N-1:0] hit_tpr;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_tmr
			localparam logic [7:0] CFG_A = 8'(tpg_pkg::TPG_OFS_TCFG0
				+ tpg_pkg::TPG_TMR_STRIDE * gi);
			localparam logic [7:0] PR_A  = 8'(tpg_pkg::TPG_OFS_TPR0
				+ tpg_pkg::TPG_TMR_STRIDE * gi);
			assign hit_tcfg[gi] = (paddr == CFG_A);
			assign hit_tpr[gi]  = (paddr == PR_A);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tcfg_r[gi].on    <= 1'b0;
					tcfg_r[gi].presc <= 3'h0;
					tcfg_r[gi].limit <= tpg_pkg::TPG_TPR_RST;
				end else if (wr_en && hit_tcfg[gi]) begin
					tcfg_r[gi].on    <= pwdata[tpg_pkg::TPG_TCFG_ON];
					tcfg_r[gi].presc <= pwdata[2:0];
				end else if (wr_en && hit_tpr[gi]) begin
					tcfg_r[gi].limit <= pwdata[7:0];
				end
			end

			// Timer runs from pclk through its own prescaler; no other source exists
			tpg_timer u_timer (
				.pclk    (pclk),
				.presetn (presetn),
				.sleep   (sleep_s2_r),
				.cfg     (tcfg_r[gi]),
				.tb      (tb[gi])
			);
		end
	endgenerate

	wire mapped = hit_ctrl | hit_dhi | hit_dlo | hit_tsel | hit_pdir
		| (|hit_tcfg) | (|hit_tpr);

	// Reserved code keeps the default timer rather than stalling
	wire [1:0] tidx = (tsel_r == tpg_pkg::TPG_TSEL_RSVD) ? 2'h0
		: tsel_r - 2'h1;
	assign tb_sel  = tb[tidx];
	assign cfg_sel = tcfg_r[tidx];

	tpg_gen u_gen (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (en_r),
		.sleep    (sleep_s2_r),
		.duty_wr  ({duty_hi_r, duty_lo_r}),
		.tb       (tb_sel),
		.limit    (cfg_sel.limit),
		.raw      (raw),
		.duty_act (duty_act)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r      <= 1'b0;
			pol_r     <= 1'b0;
			duty_hi_r <= tpg_pkg::TPG_DUTY_RST[9:2];
			duty_lo_r <= tpg_pkg::TPG_DUTY_RST[1:0];
			tsel_r    <= tpg_pkg::TPG_TSEL_RST;
			pindir_r  <= tpg_pkg::TPG_PINDIR_RST;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				en_r  <= pwdata[tpg_pkg::TPG_CTRL_EN];
				pol_r <= pwdata[tpg_pkg::TPG_CTRL_POL];
			end
			if (hit_dhi)
				duty_hi_r <= pwdata[7:0];
			if (hit_dlo)
				duty_lo_r <= pwdata[tpg_pkg::TPG_DLO_POS +: 2];
			if (hit_tsel)
				tsel_r <= pwdata[1:0];
			if (hit_pdir)
				pindir_r <= pwdata[0];
		end
	end

	// Read mux: reserved bits read zero
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (hit_ctrl) begin
			prdata_nxt[tpg_pkg::TPG_CTRL_EN]  = en_r;
			prdata_nxt[tpg_pkg::TPG_CTRL_OUT] = pwm_r;
			prdata_nxt[tpg_pkg::TPG_CTRL_POL] = pol_r;
		end
		if (hit_dhi)
			prdata_nxt[7:0] = duty_hi_r;
		if (hit_dlo)
			prdata_nxt[tpg_pkg::TPG_DLO_POS +: 2] = duty_lo_r;
		if (hit_tsel)
			prdata_nxt[1:0] = tsel_r;
		if (hit_pdir)
			prdata_nxt[0] = pindir_r;
		for (int i = 0; i < N; i++) begin
			if (hit_tcfg[i]) begin
				prdata_nxt[tpg_pkg::TPG_TCFG_ON] = tcfg_r[i].on;
				prdata_nxt[2:0] = tcfg_r[i].presc;
			end
			if (hit_tpr[i])
				prdata_nxt[7:0] = tcfg_r[i].limit;
		end
	end

	// One access cycle, zero wait states; answer comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph & ~mapped;
			if (setup_ph && !pwrite)
				prdata_r <= prdata_nxt;
		end
	end

	// Output flops; polarity applied after the disable hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_r    <= 1'b0;
			pin_oe_r <= 1'b0;
		end else begin
			if (!sleep_s2_r)
				pwm_r <= raw ^ pol_r;
			pin_oe_r <= ~pindir_r;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign pwm_out = pwm_r;
	assign pin_out = pwm_r;
	assign pin_oe  = pin_oe_r;

	// Checks
	AST_WRAP_LOADS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tb_sel.wrap && en_r && !sleep_s2_r) |=>
		duty_act == $past({duty_hi_r, duty_lo_r}))
		else $error("duty buffer not loaded at period match");
	AST_WRAP_SETS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tb_sel.wrap && en_r && !sleep_s2_r
		&& {duty_hi_r, duty_lo_r} != 10'h000) |=> raw)
		else $error("output not active after timer clear");
	AST_ZERO_DUTY: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tb_sel.wrap && en_r && !sleep_s2_r
		&& {duty_hi_r, duty_lo_r} == 10'h000) |=> !raw)
		else $error("zero duty produced active output");
	// A select change at a wrap moves the view to another timer
	AST_TIMER_CLEARS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tb_sel.wrap && !(wr_en && hit_tsel)) |=>
		(tb_sel.count == 8'h00 && tb_sel.sub == 2'h0))
		else $error("timer not cleared after period match");
	// Sleep in the middle cycle would freeze the output flop
	AST_DISABLED_LOW: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!en_r ##1 !sleep_s2_r) |=> (pwm_r == $past(pol_r)))
		else $error("disabled output not inactive");
	AST_SLEEP_HOLD: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sleep_s2_r && $past(sleep_s2_r)) |->
		($stable(pwm_r) && $stable(tb[0].count)))
		else $error("state changed during sleep");
	AST_FULL_DUTY: assert property (
		@(posedge pclk) disable iff (!presetn)
		(raw && en_r && !sleep_s2_r && !tb_sel.wrap
		&& {1'b0, duty_act} > {1'b0, cfg_sel.limit, 2'h3}) |=> raw)
		else $error("full duty output was cleared");
	// Duty beyond the period never clears, even past the limit
	AST_DUTY_CLEAR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(en_r && !sleep_s2_r && !tb_sel.wrap && tb_sel.step
		&& duty_act <= {cfg_sel.limit, 2'h3}
		&& {tb_sel.count, tb_sel.sub} + 10'h001 == duty_act) |=> !raw)
		else $error("output not cleared at duty match");
	AST_OUT_READ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && hit_ctrl) |=>
		prdata_r[tpg_pkg::TPG_CTRL_OUT] == $past(pwm_r))
		else $error("output level bit mismatch");
	AST_TSEL_RESET: assert property (
		@(posedge pclk)
		$rose(presetn) |-> tsel_r == tpg_pkg::TPG_TSEL_RST)
		else $error("timer select not at reset default");
	AST_PIN_INPUT: assert property (
		@(posedge pclk)
		!presetn |-> !pin_oe)
		else $error("pin driven during reset");

	COV_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
		tb_sel.wrap && en_r);
	COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(raw) && en_r);
	COV_SLEEP: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(sleep_s2_r) && en_r);
	COV_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_dhi);
endmodule

/* File: tpg_pin_model.sv */
// Pin pad with pull-up and pulse width monitor for the generator output
`timescale 1ns/1ps
module tpg_pin_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	input  wire logic        pwm_out,
	output logic             pad,
	output logic [15:0]      hi_len,
	output logic [15:0]      per_len
);
	logic        prev_r;
	logic [15:0] run_r;
	logic [15:0] hic_r;

	// Released pad floats up, so a missing drive shows as 1
	assign pad = pin_oe ? pin_out : 1'b1;

	// Lengths latch on each rising edge of the output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r  <= 1'b0;
			run_r   <= 16'h0000;
			hic_r   <= 16'h0000;
			hi_len  <= 16'h0000;
			per_len <= 16'h0000;
		end else begin
			prev_r <= pwm_out;
			if (pwm_out && !prev_r) begin
				per_len <= run_r;
				hi_len  <= hic_r;
				run_r   <= 16'h0001;
				hic_r   <= 16'h0001;
			end else begin
				run_r <= run_r + 16'h0001;
				hic_r <= hic_r + {15'h0000, pwm_out};
			end
		end
	end
endmodule

/* File: tb_top.sv */
// Register-level testbench for the ten-bit PWM generator
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, sleep_req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        pready, pslverr, pwm_out, pin_out, pin_oe, pad, re;
	logic [15:0] hi_len, per_len;
	int          err_total, compares;
	int          pe[4] = '{32, 8, 12, 32};
	int          he[4] = '{10, 5, 5, 10};

	tpg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .sleep_req(sleep_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
		.pin_out(pin_out), .pin_oe(pin_oe));

	tpg_pin_model peer (.pclk(pclk), .presetn(presetn),
		.pin_out(pin_out), .pin_oe(pin_oe), .pwm_out(pwm_out),
		.pad(pad), .hi_len(hi_len), .per_len(per_len));

	always #12.5 pclk = ~pclk;

	task automatic close_out;
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	// Entered just after an edge; one idle edge at the end avoids a
	// double assignment of psel when calls follow back to back
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A slave that never answers counts as a mismatch
		chk(32'(pready), 32'h1);
		rv = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rv, e);
	endtask

	task automatic hold(input logic v, input int n);
		repeat (n) begin
			@(posedge pclk);
			chk(32'(pwm_out), 32'(v));
		end
	endtask

	task automatic lens(input int p, input int h);
		repeat (100) @(posedge pclk);
		chk(32'(per_len), p);
		chk(32'(hi_len), h);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		close_out();
	end

	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; sleep_req = 1'b0;
		err_total = 0; compares = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0000);
		rd(tpg_pkg::TPG_OFS_DUTY_HI, 32'h0000_0000);
		rd(tpg_pkg::TPG_OFS_TSEL, 32'h0000_0001);
		rd(tpg_pkg::TPG_OFS_PINDIR, 32'h0000_0001);
		rd(tpg_pkg::TPG_OFS_TPR0, 32'h0000_00FF);
		chk(32'(pin_oe), 32'h0);
		rd(8'hFC, 32'h0000_0000);
		chk(32'(re), 32'h1);
		// Timer 0 prescales by two, so its count steps every eighth clock
		wr(tpg_pkg::TPG_OFS_TPR0, 32'h0000_0003);
		wr(tpg_pkg::TPG_OFS_TCFG0, 32'h0000_0081);
		wr(tpg_pkg::TPG_OFS_DUTY_HI, 32'h0000_0001);
		wr(tpg_pkg::TPG_OFS_DUTY_LO, 32'h0000_007F);
		rd(tpg_pkg::TPG_OFS_DUTY_LO, 32'h0000_0040);
		wr(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0080);
		lens(32, 10);
		wr(tpg_pkg::TPG_OFS_PINDIR, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		chk(32'(pin_oe), 32'h1);
		chk(32'(pad), 32'(pwm_out));
		wr(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0090);
		lens(32, 22);
		wr(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0010);
		repeat (3) @(posedge pclk);
		hold(1'b1, 40);
		wr(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0080);
		wr(8'h2C, 32'h0000_0001);
		wr(8'h28, 32'h0000_0080);
		wr(8'h34, 32'h0000_0002);
		wr(8'h30, 32'h0000_0080);
		// Reserved code last, so a dropped write would show the third timer
		for (int k = 0; k < 4; k++) begin
			wr(tpg_pkg::TPG_OFS_TSEL, 32'((k + 1) % 4));
			lens(pe[k], he[k]);
		end
		sleep_req <= 1'b1;
		repeat (4) @(posedge pclk);
		re = pwm_out;
		hold(re, 40);
		sleep_req <= 1'b0;
		lens(32, 10);
		wr(tpg_pkg::TPG_OFS_DUTY_HI, 32'h0000_00FF);
		wr(tpg_pkg::TPG_OFS_DUTY_LO, 32'h0000_00C0);
		repeat (40) @(posedge pclk);
		hold(1'b1, 40);
		rd(tpg_pkg::TPG_OFS_CTRL, 32'h0000_00A0);
		wr(tpg_pkg::TPG_OFS_DUTY_HI, 32'h0000_0000);
		wr(tpg_pkg::TPG_OFS_DUTY_LO, 32'h0000_0000);
		repeat (40) @(posedge pclk);
		hold(1'b0, 40);
		rd(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0080);
		// Second reset in mid-run, with the pin driven and inverted
		wr(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0090);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(pin_oe), 32'h0);
		chk(32'(pwm_out), 32'h0);
		chk(32'(pad), 32'h1);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(tpg_pkg::TPG_OFS_CTRL, 32'h0000_0000);
		rd(tpg_pkg::TPG_OFS_PINDIR, 32'h0000_0001);
		rd(tpg_pkg::TPG_OFS_TSEL, 32'h0000_0001);
		close_out();
	end
endmodule
